/* File: rtl/rf_frame_map.svh */
`ifndef RF_FRAME_MAP_SVH
`define RF_FRAME_MAP_SVH
// register word indices (printed offsets are not all multiples of four: byte address is index * 4)
`define RX_CRC_CTRL_IDX 8'h2D
`define TX_BIT_CTRL_IDX 8'h2E
`define TX_PULSE_IDX 8'h2F
`define STATUS_IDX 8'h40
`define MASK_IDX 8'h41
`define STATE_IDX 8'h42
// field positions
`define FORCE_COPY_BIT 7
`define ALIGN_BIT 4
`define PAYLOAD_BIT 3
`define INVERT_BIT 1
`define CHECK_EN_BIT 0
// reset values
`define CTRL_RESET 8'h00
// presets
`define P16_1 16'h6363
`define P16_2 16'hA671
`define P16_3 16'hFFFE
`define P16_7 16'hFFFF
`define P8_1 8'h12
`define P8_2 8'hBF
`define P8_3 8'hFD
`define P8_7 8'hFF
`define P5_1 5'h12
`define P5_7 5'h1F
// etu length in carrier clocks
`define ETU_CLOCKS 8'h80
`endif

/* File: rtl/rf_frame_pkg.sv */
package rf_frame_pkg;
   typedef enum logic [1:0] {
      CHK_CRC5 = 2'h0,
      CHK_CRC8 = 2'h1,
      CHK_CRC16 = 2'h2,
      CHK_RES = 2'h3
   } check_type_type;
   typedef struct packed {
      logic force_crc_copy;
      logic [2:0] receive_preset_select;
      check_type_type receive_check_type;
      logic receive_check_invert;
      logic receive_check_enable;
   } rx_ctrl_type;
   typedef struct packed {
      logic [2:0] unused;
      logic start_alignment;
      logic payload_send_enable;
      logic [2:0] final_byte_length;
   } tx_ctrl_type;
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } byte_beat_type;
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_WAIT = 4'b0010,
      TX_SYMBOL = 4'b0100,
      TX_DATA = 4'b1000
   } tx_state_type;
endpackage

/* File: rtl/rf_frame_ctrl.sv */
`timescale 1ns/10ps
`include "rf_frame_map.svh"
// Summary of operation
// - force copy bit stores received CRC bytes
// - CRC16 preset chosen by three-bit code
// - CRC8 and CRC5 presets by same code
// - type field selects CRC5, CRC8, CRC16
// - invert bit compares against inverted CRC
// - check enable gates error flag setting
// - alignment bit keeps starts on ETU grid
// - payload disabled sends single symbol only
// - final byte length, zero means eight
// - LSB first, surplus high bits dropped
// - pulse lasts width value plus one clocks
// - pulse ends by end of bit
// - pulse start from pulse start select
// - width used only in Miller mode
// - width also applies to start/stop symbols
// - user preset from nonvolatile configuration
module rf_frame_ctrl #(
   parameter int ETU_LEN = 128
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // configuration and mode inputs
   input wire logic [15:0] user_preset,
   input wire logic miller_mode,
   input wire logic [6:0] pulse_start_select,
   // carrier clock enable tick (same domain)
   input wire logic carrier_tick,
   // receive stream
   input wire rf_frame_pkg::byte_beat_type rx_in,
   input wire logic rx_start,
   output rf_frame_pkg::byte_beat_type fifo_out,
   // transmit
   input wire logic tx_start,
   input wire rf_frame_pkg::byte_beat_type tx_in,
   output logic tx_ready,
   output logic tx_mod,
   output logic tx_busy
);
   import rf_frame_pkg::*;

   ////////////////////////////////////////////////////////////////
   // registers
   rx_ctrl_type rxc_r, rxc_nxt;
   tx_ctrl_type txc_r, txc_nxt;
   logic [7:0] width_r, width_nxt;
   logic [1:0] stat_r, stat_nxt;
   logic [1:0] mask_r, mask_nxt;
   logic [7:0] idx;
   logic wr, rd_ok;
   logic crc_err_ev, tx_done_ev;
   // transmit state is declared here because the read mux shows it
   tx_state_type tx_st_r, tx_st_nxt;

   assign idx = paddr[9:2];
   assign wr = psel & penable & pwrite & clk_en;
   assign pready = 1'b1; // zero wait states
   assign irq = |(stat_r & mask_r);

   // address decode and register writes
   always_comb begin
      rxc_nxt = rxc_r;
      txc_nxt = txc_r;
      width_nxt = width_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      rd_ok = 1'b1;
      if (idx == `RX_CRC_CTRL_IDX) begin
         if (wr) rxc_nxt = rx_ctrl_type'(pwdata[7:0]);
      end else if (idx == `TX_BIT_CTRL_IDX) begin
         if (wr) txc_nxt = tx_ctrl_type'({3'h0, pwdata[4:0]});
      end else if (idx == `TX_PULSE_IDX) begin
         if (wr) width_nxt = pwdata[7:0];
      end else if (idx == `MASK_IDX) begin
         if (wr) mask_nxt = pwdata[1:0];
      end else if (idx == `STATUS_IDX) begin
         if (wr) stat_nxt = stat_r & ~pwdata[1:0];
      end else if (idx == `STATE_IDX) begin
         rd_ok = 1'b1;
      end else begin
         rd_ok = 1'b0;
      end
      if (rx_start & clk_en) stat_nxt[0] = 1'b0;
      // set wins over clear
      if (crc_err_ev) stat_nxt[0] = 1'b1;
      if (tx_done_ev) stat_nxt[1] = 1'b1;
   end

   always_comb begin
      prdata = 32'h0;
      if (idx == `RX_CRC_CTRL_IDX) begin
         prdata[7:0] = rxc_r;
      end else if (idx == `TX_BIT_CTRL_IDX) begin
         prdata[7:0] = txc_r;
      end else if (idx == `TX_PULSE_IDX) begin
         prdata[7:0] = width_r;
      end else if (idx == `STATUS_IDX) begin
         prdata[1:0] = stat_r;
      end else if (idx == `MASK_IDX) begin
         prdata[1:0] = mask_r;
      end else if (idx == `STATE_IDX) begin
         prdata[3:0] = tx_st_r;
      end
   end
   assign pslverr = psel & penable & ~rd_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxc_r <= rx_ctrl_type'(`CTRL_RESET);
         txc_r <= tx_ctrl_type'(`CTRL_RESET);
         width_r <= `CTRL_RESET;
         stat_r <= 2'h0;
         mask_r <= 2'h0;
      end else if (clk_en) begin
         rxc_r <= rxc_nxt;
         txc_r <= txc_nxt;
         width_r <= width_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // receive crc check: serial lsb-first update per byte
   logic [15:0] crc_r, crc_nxt, preset, poly, topmask, calc;
   logic [1:0] cnt_r, cnt_nxt;
   logic [15:0] last2_r, last2_nxt;
   // crc value before the latest beat; the crc16 tail is checked against it
   logic [15:0] prev_r, prev_nxt;
   byte_beat_type fo_nxt;
   logic err_pulse;

   // preset table; codes 4 and 5 give zero, host must avoid them
   always_comb begin
      preset = 16'h0;
      case (rxc_r.receive_check_type)
         CHK_CRC16: begin
            case (rxc_r.receive_preset_select)
               3'h1: preset = `P16_1;
               3'h2: preset = `P16_2;
               3'h3: preset = `P16_3;
               3'h6: preset = user_preset;
               3'h7: preset = `P16_7;
               default: preset = 16'h0;
            endcase
         end
         CHK_CRC8: begin
            case (rxc_r.receive_preset_select)
               3'h1: preset = {8'h0, `P8_1};
               3'h2: preset = {8'h0, `P8_2};
               3'h3: preset = {8'h0, `P8_3};
               3'h6: preset = {8'h0, user_preset[7:0]};
               3'h7: preset = {8'h0, `P8_7};
               default: preset = 16'h0;
            endcase
         end
         default: begin
            case (rxc_r.receive_preset_select)
               3'h1: preset = {11'h0, `P5_1};
               3'h6: preset = {11'h0, user_preset[4:0]};
               3'h7: preset = {11'h0, `P5_7};
               default: preset = 16'h0;
            endcase
         end
      endcase
   end

   // reflected polynomials per type
   always_comb begin
      case (rxc_r.receive_check_type)
         CHK_CRC16: begin
            poly = 16'h8408;
            topmask = 16'hFFFF;
         end
         CHK_CRC8: begin
            poly = 16'h00B8;
            topmask = 16'h00FF;
         end
         default: begin
            poly = 16'h0014;
            topmask = 16'h001F;
         end
      endcase
   end

   // one byte through the reflected register, lsb first
   // the loop unrolls to eight xor stages; fine at this clock rate
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                            input logic [15:0] p);
      logic [15:0] v;
      v = c;
      for (int i = 0; i < 8; i++) begin
         if (v[0] ^ d[i]) v = (v >> 1) ^ p;
         else v = v >> 1;
      end
      return v;
   endfunction

   always_comb begin
      crc_nxt = crc_r;
      cnt_nxt = cnt_r;
      last2_nxt = last2_r;
      prev_nxt = prev_r;
      fo_nxt = '0;
      err_pulse = 1'b0;
      // the crc16 tail is two bytes: its reference excludes the low tail byte
      // crc5 and crc8 tails are one byte, so the running value is the reference
      calc = (rxc_r.receive_check_type == CHK_CRC16) ? prev_r & topmask : crc_r & topmask;
      if (rxc_r.receive_check_invert) calc = ~calc & topmask;
      if (rx_start) begin
         crc_nxt = preset;
         cnt_nxt = 2'h0;
      end else if (rx_in.valid) begin
         crc_nxt = crc_byte(crc_r, rx_in.data, poly) & topmask;
         // crc bytes are the trailing ones; the last byte passes only when copying
         fo_nxt = rx_in;
         if (!rxc_r.force_crc_copy && rx_in.last) fo_nxt = '0;
         if (rx_in.last) begin
            if (rxc_r.receive_check_type == CHK_CRC16) begin
               // tail arrives low byte first
               err_pulse = ({rx_in.data, last2_r[7:0]} != calc);
            end else begin
               err_pulse = ({8'h0, rx_in.data} & topmask) != calc;
            end
         end
         last2_nxt = {last2_r[7:0], rx_in.data};
         prev_nxt = crc_r;
      end
   end
   assign crc_err_ev = err_pulse & rxc_r.receive_check_enable & clk_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_r <= 16'h0;
         cnt_r <= 2'h0;
         last2_r <= 16'h0;
         prev_r <= 16'h0;
         fifo_out <= '0;
      end else if (clk_en) begin
         crc_r <= crc_nxt;
         cnt_r <= cnt_nxt;
         last2_r <= last2_nxt;
         prev_r <= prev_nxt;
         fifo_out <= fo_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmit bit control
   logic [7:0] sh_r, sh_nxt;
   logic [3:0] bits_r, bits_nxt;
   logic last_r, last_nxt;
   logic [7:0] etu_r, etu_nxt;
   logic [8:0] pw_r, pw_nxt;
   logic mod_nxt, bit_end;

   assign bit_end = carrier_tick && (etu_r == 8'(ETU_LEN - 1));
   // a byte is taken at the bit boundary so that its first bit keeps a full slot;
   // loading later would let bit zero miss its pulse point
   assign tx_ready = clk_en && txc_r.payload_send_enable && (
      (tx_st_r == TX_WAIT && (!txc_r.start_alignment || bit_end)) ||
      (tx_st_r == TX_DATA && !last_r && (bits_r == 4'h0 || (bits_r == 4'h1 && bit_end))));
   assign tx_busy = (tx_st_r != TX_IDLE);
   assign tx_done_ev = clk_en && bit_end && (tx_st_r == TX_SYMBOL ||
      (tx_st_r == TX_DATA && bits_r == 4'h1 && last_r));

   always_comb begin
      tx_st_nxt = tx_st_r;
      sh_nxt = sh_r;
      bits_nxt = bits_r;
      last_nxt = last_r;
      etu_nxt = etu_r;
      pw_nxt = pw_r;
      mod_nxt = tx_mod;
      // etu counter runs free so grid starts stay whole etus apart
      if (carrier_tick) etu_nxt = bit_end ? 8'h0 : etu_r + 8'h1;
      case (tx_st_r)
         TX_IDLE: begin
            if (tx_start) begin
               tx_st_nxt = TX_WAIT;
            end
         end
         TX_WAIT: begin
            // aligned start waits until the running bit ends
            if (!txc_r.start_alignment || bit_end) begin
               tx_st_nxt = txc_r.payload_send_enable ? TX_DATA : TX_SYMBOL;
               bits_nxt = 4'h0;
               last_nxt = 1'b0;
               // a free start restarts the bit timer here
               if (!txc_r.start_alignment) etu_nxt = 8'h0;
               // first byte enters with the first bit period
               if (tx_ready && tx_in.valid) begin
                  sh_nxt = tx_in.data;
                  last_nxt = tx_in.last;
                  bits_nxt = (tx_in.last && txc_r.final_byte_length != 3'h0) ?
                     {1'b0, txc_r.final_byte_length} : 4'h8;
               end
            end
         end
         TX_SYMBOL: begin
            if (bit_end) tx_st_nxt = TX_IDLE;
         end
         default: begin
            if (tx_ready && tx_in.valid) begin
               sh_nxt = tx_in.data;
               last_nxt = tx_in.last;
               // zero length means full byte; high bits dropped
               bits_nxt = (tx_in.last && txc_r.final_byte_length != 3'h0) ?
                  {1'b0, txc_r.final_byte_length} : 4'h8;
            end else if (bit_end && bits_r != 4'h0) begin
               sh_nxt = sh_r >> 1;
               bits_nxt = bits_r - 4'h1;
               if (bits_r == 4'h1 && last_r) tx_st_nxt = TX_IDLE;
            end
         end
      endcase
      // pulse generation: starts at the selected point in the bit
      if (carrier_tick && tx_st_r inside {TX_SYMBOL, TX_DATA}) begin
         if (etu_r == {1'b0, pulse_start_select} &&
             (tx_st_r == TX_SYMBOL || (bits_r != 4'h0 && !sh_r[0]))) begin
            mod_nxt = 1'b1;
            // miller uses programmed width, else a fixed single clock
            pw_nxt = miller_mode ? {1'b0, width_r} : 9'h0;
         end else if (mod_nxt) begin
            if (pw_r == 9'h0) mod_nxt = 1'b0;
            else pw_nxt = pw_r - 9'h1;
         end
      end
      if (bit_end) mod_nxt = 1'b0;
      if (tx_st_nxt == TX_IDLE) mod_nxt = 1'b0;
   end

   // transmit state; clk_en low freezes the bit timer as well
   // so a stalled carrier stretches the bit instead of cutting it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r <= TX_IDLE;
         sh_r <= 8'h0;
         bits_r <= 4'h0;
         last_r <= 1'b0;
         etu_r <= 8'h0;
         pw_r <= 9'h0;
         tx_mod <= 1'b0;
      end else if (clk_en) begin
         tx_st_r <= tx_st_nxt;
         sh_r <= sh_nxt;
         bits_r <= bits_nxt;
         last_r <= last_nxt;
         etu_r <= etu_nxt;
         pw_r <= pw_nxt;
         tx_mod <= mod_nxt;
      end
   end
endmodule

/* File: sim/rf_frame_monitor.sv */
`timescale 1ns/10ps
module rf_frame_monitor #(
   parameter int ETU_LEN = 128
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // streams
   input wire rf_frame_pkg::byte_beat_type rx_in,
   input wire rf_frame_pkg::byte_beat_type fifo_out,
   input wire logic tx_start,
   input wire logic tx_ready,
   input wire logic tx_mod,
   input wire logic tx_busy
);
   import rf_frame_pkg::*;
   logic [8:0] high_r;
   logic [8:0] high_nxt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // length of the running pulse; assumes a carrier tick every clock
   always_comb begin
      high_nxt = tx_mod ? high_r + 9'h001 : 9'h000;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         high_r <= 9'h000;
      else
         high_r <= high_nxt;
   end
   //////////////////////////////////////////////////////////////////////
   pready_high_a: assert property (pready) else $error("pready low");
   slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   unmapped_zero_a: assert property (psel && penable && !pwrite && pslverr |->
      prdata == 32'h00000000) else $error("refused read not zero");
   fifo_echo_a: assert property (rx_in.valid && !rx_in.last |=> fifo_out.valid &&
      fifo_out.data == $past(rx_in.data)) else $error("fifo beat lost");
   fifo_cause_a: assert property (fifo_out.valid |-> $past(rx_in.valid))
      else $error("fifo beat without cause");
   mod_idle_a: assert property (!tx_busy && !$past(tx_busy) |-> !tx_mod)
      else $error("modulation while idle");
   busy_start_a: assert property (tx_start && !tx_busy |=> tx_busy)
      else $error("start not taken");
   pulse_bound_a: assert property (high_r <= ETU_LEN) else $error("pulse past bit end");
   ready_busy_a: assert property (tx_ready |-> tx_busy) else $error("ready while idle");
   cover property (rx_in.valid && rx_in.last);
   cover property ($rose(tx_mod));
   cover property (pslverr);
endmodule
bind rf_frame_ctrl rf_frame_monitor #(.ETU_LEN(ETU_LEN)) mon_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_in(rx_in), .fifo_out(fifo_out), .tx_start(tx_start),
   .tx_ready(tx_ready), .tx_mod(tx_mod), .tx_busy(tx_busy));

/* File: sim/rf_card_model.sv */
`timescale 1ns/10ps
module rf_card_model (
   // clock
   input wire logic pclk,
   // rf side
   input wire logic tx_mod,
   output rf_frame_pkg::byte_beat_type rx_in,
   output logic rx_start,
   // observation
   output int pulses,
   output int width
);
   import rf_frame_pkg::*;
   int run = 0;
   initial begin
      rx_in = 10'h000;
      rx_start = 1'b0;
      pulses = 0;
      width = 0;
   end
   // counts pulses seen on the field and keeps the last width
   always @(posedge pclk) begin
      if (tx_mod && run == 0) pulses <= pulses + 1;
      if (!tx_mod && run != 0) width <= run;
      run <= tx_mod ? run + 1 : 0;
   end
   // card answer: start mark, then one byte a clock, crc bytes last
   task automatic send(input logic [7:0] b[$]);
      @(posedge pclk) rx_start <= 1'b1;
      foreach (b[i]) begin
         @(posedge pclk) rx_start <= 1'b0;
         rx_in <= {1'b1, i == b.size() - 1, b[i]};
      end
      // released line must not keep showing the last byte
      @(posedge pclk) rx_in <= {2'b00, ~b[b.size() - 1]};
   endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`include "rf_frame_map.svh"
module testbench;
   import rf_frame_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, q;
   logic pready, pslverr, irq, e, rx_start, tx_ready, tx_mod, tx_busy;
   logic miller_mode = 1'b0;
   logic tx_start = 1'b0;
   byte_beat_type rx_in, fifo_out;
   byte_beat_type tx_in = 10'h3B2;
   int pulses, width, p0, b0;
   int fail_count = 0;
   int n_checks = 0;
   int beats = 0;
   logic [15:0] pre [6] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFE, 16'h1234, 16'hFFFF};
   logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
   int zeros [3] = '{4, 2, 3};
   logic [2:0] lens [3] = '{3'h0, 3'h3, 3'h6};
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) if (fifo_out.valid === 1'b1) beats <= beats + 1;
   //////////////////////////////////////////////////////////////////////
   rf_frame_ctrl #(.ETU_LEN(8)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .user_preset(16'h1234), .miller_mode(miller_mode), .pulse_start_select(7'h00),
      .carrier_tick(1'b1), .rx_in(rx_in), .rx_start(rx_start), .fifo_out(fifo_out),
      .tx_start(tx_start), .tx_in(tx_in), .tx_ready(tx_ready), .tx_mod(tx_mod),
      .tx_busy(tx_busy));
   rf_card_model card_u (.pclk(pclk), .tx_mod(tx_mod), .rx_in(rx_in), .rx_start(rx_start),
      .pulses(pulses), .width(width));
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; waits for pready, no fixed latency assumed
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [15:0] crc16(input logic [15:0] p, input logic [7:0] b[$]);
      logic [15:0] c;
      c = p;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return c;
   endfunction
   // two data bytes and a crc16 tail, low byte first
   task automatic frame(input logic [15:0] p, input logic inv, input logic bad);
      logic [7:0] b[$];
      logic [15:0] c;
      b = '{8'h26, 8'h93};
      c = crc16(p, b) ^ {16{inv}} ^ {15'h0000, bad};
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      b0 = beats;
      card_u.send(b);
      repeat (3) @(posedge pclk);
      apb(0, `STATUS_IDX, 0);
   endtask
   task automatic send_tx();
      p0 = pulses;
      @(posedge pclk) tx_start <= 1'b1;
      @(posedge pclk) tx_start <= 1'b0;
      repeat (2) @(posedge pclk);
      while (tx_busy !== 1'b0) @(posedge pclk);
      repeat (2) @(posedge pclk);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(0, `RX_CRC_CTRL_IDX + i[7:0], 0);
         chk(q, 32'h00000000);
         apb(1, `RX_CRC_CTRL_IDX + i[7:0], 32'h00000015);
         apb(0, `RX_CRC_CTRL_IDX + i[7:0], 0);
         chk(q, 32'h00000015);
      end
      apb(0, 8'h10, 0);
      chk({e, q[30:0]}, 32'h80000000);
      for (int i = 0; i < 6; i++) begin
         apb(1, `RX_CRC_CTRL_IDX, {24'h000000, 1'b0, code[i], 4'h9});
         frame(pre[i], 0, 0);
         chk(q & 32'h1, 32'h0);
         chk(beats - b0, 3);
         frame(pre[i], 0, 1);
         chk(q & 32'h1, 32'h1);
         apb(1, `STATUS_IDX, 32'h1);
         apb(0, `STATUS_IDX, 0);
         chk(q & 32'h1, 32'h0);
      end
      apb(1, `MASK_IDX, 32'h1);
      apb(1, `RX_CRC_CTRL_IDX, 32'h0000009B); // copy on for unaligned crc use
      frame(16'h6363, 1, 0);
      chk(q & 32'h1, 32'h0);
      chk(beats - b0, 4);
      frame(16'h6363, 0, 0);
      chk({q[0], irq}, 2'b11);
      apb(1, `MASK_IDX, 32'h0);
      @(negedge pclk);
      chk(irq, 1'b0);
      apb(1, `MASK_IDX, 32'h1);
      @(negedge pclk);
      chk(irq, 1'b1);
      frame(16'h6363, 1, 0);
      chk({q[0], irq}, 2'b00);
      apb(1, `RX_CRC_CTRL_IDX, 32'h0000001A);
      frame(16'h6363, 0, 1);
      chk(q & 32'h1, 32'h0);
      for (int i = 0; i < 3; i++) begin
         apb(1, `TX_BIT_CTRL_IDX, {24'h000000, 5'h03, lens[i]});
         send_tx();
         chk(pulses - p0, zeros[i]);
      end
      apb(1, `TX_PULSE_IDX, 32'h2);
      miller_mode <= 1'b1;
      send_tx();
      chk(width, 3);
      miller_mode <= 1'b0;
      send_tx();
      chk(width, 1);
      apb(1, `STATUS_IDX, 32'h2);
      apb(1, `TX_BIT_CTRL_IDX, 32'h00000010);
      send_tx();
      apb(0, `STATUS_IDX, 0);
      chk(q & 32'h2, 32'h2);
      final_report();
   end
endmodule
